// File: sai_pkg.sv
// Constants, states and state records shared by the serial converter interface.
`default_nettype none
package sai_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          RES_BITS  = 10;
    localparam int          CFG_BITS  = 2;
    localparam logic [3:0]  TOP_IDX   = 4'h9;
    localparam logic [3:0]  LAST_CFG  = 4'h1;
    localparam logic [3:0]  CNT_ZERO  = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CFG,
        ST_NULL_BIT,
        ST_CONV,
        ST_ZERO_TAIL
    } sai_phase_e;

    typedef struct packed {
        logic [3:0]          meta;
        logic [3:0]          sync;
        logic                sclk_d;
        sai_phase_e          state;
        logic [3:0]          cnt;
        logic [3:0]          bitidx;
        logic [CFG_BITS-1:0] cfg;
        logic                ch;
        logic                diff;
        logic                dout;
        logic                oe;
        logic                track;
        logic                shdn;
    } sai_core_s;

    typedef struct packed {
        logic [RES_BITS-1:0] code;
    } sai_sar_s;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam sai_core_s CORE_RST = '{
        meta: 4'h0, sync: 4'h0, sclk_d: 1'b0, state: ST_IDLE,
        cnt: 4'h0, bitidx: 4'h0, cfg: '0, ch: 1'b0, diff: 1'b0,
        dout: 1'b0, oe: 1'b0, track: 1'b0, shdn: 1'b1
    };
    localparam sai_sar_s SAR_RST = '{code: 10'h000};

endpackage : sai_pkg
`default_nettype wire

// File: sai_sar.sv
// Successive approximation register that resolves one result bit per step.
`timescale 1ns/1ps
`default_nettype none
module sai_sar
    import sai_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // Control
    input  wire logic                clear_i,
    input  wire logic                step_i,
    input  wire logic [3:0]          idx_i,
    input  wire logic                comp_i,
    // Trial code
    output logic      [RES_BITS-1:0] code_o
);

    sai_sar_s r;
    sai_sar_s next_r;

    function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
        bit_mask = '0;
        bit_mask[idx] = 1'b1;
    endfunction : bit_mask

    // ------------------------------------------------------------
    // Bit decisions
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (clear_i) begin
            next_r.code = bit_mask(TOP_IDX);
        end else if (step_i) begin
            next_r.code = comp_i ? (r.code | bit_mask(idx_i)) : (r.code & ~bit_mask(idx_i));
            if (idx_i != CNT_ZERO) begin
                next_r.code = next_r.code | bit_mask(idx_i - 4'h1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= SAR_RST;
        end else begin
            r <= next_r;
        end
    end

    assign code_o = r.code;

endmodule : sai_sar
`default_nettype wire

// File: sai_core.sv
// Serial readout interface of a 10-bit sampling converter, device end.
// How it works
// - Config in first byte; top two bits end it.
// - Second byte carries bits seven down to zero.
// - Output timing counts from the received start bit.
// - Zeros follow the last bit until deselect.
// - Output floats during idle, configuration and deselect.
// - Sixteen-clock select toggling repeats whole conversions.
// - Received address bit picks the input channel.
// - Shutdown entered automatically after each conversion.
`timescale 1ns/1ps
`default_nettype none
module sai_core
    import sai_pkg::*;
(
    // Clock and reset
    input  wire logic                CORE_CLK_I,
    input  wire logic                RST_B_I,
    // Serial pins from the host
    input  wire logic                SCLK_I,
    input  wire logic                CS_B_I,
    input  wire logic                DIN_I,
    // Serial data pin back to the host
    output logic                     DOUT_O,
    output logic                     DOUT_OE_O,
    // Analog front end
    input  wire logic                COMP_I,
    output logic                     CH_SEL_O,
    output logic                     DIFF_MODE_O,
    output logic                     TRACK_O,
    output logic                     SHUTDOWN_O,
    output logic      [RES_BITS-1:0] DAC_CODE_O
);

    sai_core_s r;
    sai_core_s next_r;
    logic      rise;
    logic      fall;
    logic      cs_hi;
    logic      din;
    logic      comp;
    logic      sar_clear;
    logic      sar_step;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // All four pins are asynchronous to the core clock, so only the
    // second stage and the delayed clock copy feed any decision.
    always_comb begin
        rise  = r.sync[3] & ~r.sclk_d;
        fall  = ~r.sync[3] & r.sclk_d;
        cs_hi = r.sync[2];
        din   = r.sync[1];
        comp  = r.sync[0];
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.meta   = {SCLK_I, CS_B_I, DIN_I, COMP_I};
        next_r.sync   = r.meta;
        next_r.sclk_d = r.sync[3];
        sar_clear     = 1'b0;
        sar_step      = 1'b0;
        if (cs_hi) begin
            next_r.state = ST_IDLE;
            next_r.oe    = 1'b0;
            next_r.dout  = 1'b0;
            next_r.track = 1'b0;
            next_r.shdn  = 1'b1;
        end else begin
            unique case (r.state)
                ST_IDLE: begin
                    if (rise && din) begin
                        next_r.state = ST_CFG;
                        next_r.cnt   = CNT_ZERO;
                        next_r.track = 1'b1;
                        next_r.shdn  = 1'b0;
                        sar_clear    = 1'b1;
                    end
                end
                ST_CFG: begin
                    if (rise) begin
                        next_r.cfg = {r.cfg[CFG_BITS-2:0], din};
                        next_r.cnt = r.cnt + 4'h1;
                        if (r.cnt == LAST_CFG) begin
                            next_r.ch    = din;
                            next_r.diff  = ~r.cfg[0];
                            next_r.state = ST_NULL_BIT;
                        end
                    end
                end
                ST_NULL_BIT: begin
                    if (fall) begin
                        next_r.oe     = 1'b1;
                        next_r.dout   = 1'b0;
                        next_r.track  = 1'b0;
                        next_r.bitidx = TOP_IDX;
                        next_r.state  = ST_CONV;
                    end
                end
                ST_CONV: begin
                    // One result bit per falling edge.
                    if (fall) begin
                        sar_step    = 1'b1;
                        next_r.dout = comp;
                        if (r.bitidx == CNT_ZERO) begin
                            next_r.shdn  = 1'b1;
                            next_r.state = ST_ZERO_TAIL;
                        end else begin
                            next_r.bitidx = r.bitidx - 4'h1;
                        end
                    end
                end
                ST_ZERO_TAIL: begin
                    if (fall) begin
                        next_r.dout = 1'b0;
                    end
                end
                // A corrupted state code falls back to idle rather than hanging.
                default: begin
                    next_r.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= CORE_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Approximation register
    // ------------------------------------------------------------
    sai_sar u_sar (
        .clk_i   (CORE_CLK_I),
        .rst_b_i (RST_B_I),
        .clear_i (sar_clear),
        .step_i  (sar_step),
        .idx_i   (r.bitidx),
        .comp_i  (comp),
        .code_o  (DAC_CODE_O)
    );

    assign DOUT_O      = r.dout;
    assign DOUT_OE_O   = r.oe;
    assign CH_SEL_O    = r.ch;
    assign DIFF_MODE_O = r.diff;
    assign TRACK_O     = r.track;
    assign SHUTDOWN_O  = r.shdn;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_deselect_float: assert property (cs_hi |=> !DOUT_OE_O)
        else $error("Output still driven after deselect.");

    a_idle_float: assert property (r.state == ST_IDLE |-> !DOUT_OE_O)
        else $error("Output driven while idle.");

    a_tail_zero: assert property ((r.state == ST_ZERO_TAIL && fall && !cs_hi)
        |=> DOUT_OE_O && !DOUT_O)
        else $error("Nonzero bit after the last result bit.");

    a_bit_order: assert property ((r.state == ST_CONV && fall && !cs_hi)
        |=> DOUT_O == $past(comp) && DOUT_OE_O)
        else $error("Result bit does not match its decision.");

    a_null_first: assert property ((r.state == ST_NULL_BIT && fall && !cs_hi)
        |=> DOUT_OE_O && !DOUT_O && r.state == ST_CONV && r.bitidx == TOP_IDX)
        else $error("Null bit or top bit index wrong.");

    a_start_timed: assert property ((r.state == ST_IDLE && !cs_hi && rise && din)
        |=> r.state == ST_CFG && TRACK_O && !SHUTDOWN_O)
        else $error("Start bit not taken.");

    a_shutdown_end: assert property ((r.state == ST_CONV && fall && !cs_hi
        && r.bitidx == CNT_ZERO) |=> SHUTDOWN_O && r.state == ST_ZERO_TAIL)
        else $error("No shutdown after conversion.");

    a_chan_latch: assert property ((r.state == ST_CFG && rise && !cs_hi
        && r.cnt == LAST_CFG) |=> CH_SEL_O == $past(din))
        else $error("Channel select not latched.");

    a_mode_latch: assert property ((r.state == ST_CFG && rise && !cs_hi
        && r.cnt == LAST_CFG) |=> DIFF_MODE_O == !$past(r.cfg[0]))
        else $error("Input mode not latched.");

    a_cfg_float: assert property (r.state == ST_CFG |-> !DOUT_OE_O)
        else $error("Output driven during configuration.");

    a_frame_rearm: assert property (cs_hi |=> r.state == ST_IDLE ##1 !DOUT_OE_O)
        else $error("Frame not rearmed after deselect.");

endmodule : sai_core
`default_nettype wire

// File: sai_host.sv
// Host-side model that frames exchanges on the shared serial wire.
`timescale 1ns/1ps
`default_nettype none
module sai_host #(
    parameter int HALF = 8
) (
    // Core clock and observed pins
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic oe_i,
    // Pins driven toward the device
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      din_o,
    output logic      din_en_o
);
    initial begin
        sclk_o   = 1'b0;
        cs_b_o   = 1'b1;
        din_o    = 1'b0;
        din_en_o = 1'b0;
    end

    // Half periods of eight core cycles leave room for the pin synchronisers.
    task automatic frame(input int n, input logic [1:0] cfg,
                         output logic [19:0] rx, output logic [19:0] oe);
        logic [4:0] word;
        word = {2'b00, 1'b1, cfg};
        rx   = '0;
        oe   = '0;
        @(negedge clk_i) cs_b_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            din_en_o = (i < 5);
            din_o    = (i < 5) ? word[4 - i] : 1'b0;
            repeat (HALF) @(negedge clk_i);
            rx       = {rx[18:0], line_i};
            oe       = {oe[18:0], oe_i};
            sclk_o   = 1'b1;
            repeat (HALF) @(negedge clk_i);
            sclk_o   = 1'b0;
        end
        repeat (HALF) @(negedge clk_i);
        din_en_o = 1'b0;
        cs_b_o   = 1'b1;
        repeat (2 * HALF) @(negedge clk_i);
    endtask : frame
endmodule : sai_host
`default_nettype wire

// File: test_serial_adc_host_interface.sv
// Self-checking bench for the serial converter interface.
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_host_interface;
    import sai_pkg::*;
    logic                clk, rst_b, sclk, cs_b, din, din_en, line, comp;
    logic                dout, dout_oe, ch, diff, track, shdn;
    logic [RES_BITS-1:0] dac, vin;
    logic [19:0]         rx, oe;
    int                  error_cnt, check_count, cycles;

    // The shared wire idles high through a pull-up when nobody drives it.
    assign line = dout_oe ? dout : (din_en ? din : 1'b1);

    sai_host host_u (.clk_i(clk), .line_i(line), .oe_i(dout_oe), .sclk_o(sclk),
        .cs_b_o(cs_b), .din_o(din), .din_en_o(din_en));
    sai_core dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b), .SCLK_I(sclk), .CS_B_I(cs_b),
        .DIN_I(line), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .COMP_I(comp),
        .CH_SEL_O(ch), .DIFF_MODE_O(diff), .TRACK_O(track), .SHUTDOWN_O(shdn),
        .DAC_CODE_O(dac));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Comparator stand-in: high while the input is at or above the trial code.
    always @(negedge clk) comp <= (vin >= dac);

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // One framed exchange of n clocks, judged bit by bit on the wire.
    task automatic run(input int n, input logic [1:0] cfg, input logic [9:0] v);
        logic [19:0] e;
        vin = v;
        e   = {4'h0, 2'b00, 1'b1, cfg, 1'b0, v};
        e   = (n >= 16) ? e << (n - 16) : e >> (16 - n);
        host_u.frame(n, cfg, rx, oe);
        check(rx, e);
        check(oe, (20'h1 << (n - 5)) - 20'h1);
        check({19'h0, dout_oe}, 20'h0);
        if (n == 16) begin
            check({4'h0, rx[15:8] & 8'h03, rx[7:0]}, {10'h0, v});
        end
        if (n >= 16) begin
            check({10'h0, dac}, {10'h0, v});
        end
    endtask : run

    task automatic t_reset();
        check({15'h0, shdn, dout_oe, track, ch, diff}, 20'h10);
        check({10'h0, dac}, 20'h0);
    endtask : t_reset

    task automatic t_modes();
        logic [9:0] vals [4] = '{10'h249, 10'h3FF, 10'h000, 10'h155};
        for (int c = 0; c < 4; c++) begin
            run(16, 2'(c), vals[c]);
            check({18'h0, ch, diff}, {18'h0, c[0], ~c[1]});
            check({19'h0, shdn}, 20'h1);
        end
    endtask : t_modes

    task automatic t_tail();
        run(20, 2'b11, 10'h2AA);
    endtask : t_tail

    task automatic t_abort();
        run(12, 2'b10, 10'h3C5);
        run(16, 2'b01, 10'h1A6);
    endtask : t_abort

    initial begin
        rst_b       = 1'b0;
        vin         = '0;
        comp        = 1'b0;
        error_cnt   = 0;
        check_count = 0;
        cycles      = 0;
        repeat (3) @(negedge clk);
        t_reset();
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        t_modes();
        t_tail();
        t_abort();
        report_and_stop();
    end
endmodule : test_serial_adc_host_interface
`default_nettype wire
